// *** logic/ged_consts.vh ***
/*
 Constants for the pin edge interrupt block: register offsets, field widths,
 reset values. Assumes a 16-bit register port addressed at the printed offsets.
*/
`ifndef GED_CONSTS_VH
`define GED_CONSTS_VH

// Pin counts and register layout
`define GED_PINS        24
`define GED_LO_PINS     16
`define GED_HI_PINS     8
`define GED_ADDR_W      16
`define GED_DATA_W      16

// Register offsets
`define GED_OFS_RISE_LO 16'h0310
`define GED_OFS_RISE_HI 16'h0312
`define GED_OFS_FALL_LO 16'h0314
`define GED_OFS_FALL_HI 16'h0316
`define GED_OFS_STAT_LO 16'h0318
`define GED_OFS_STAT_HI 16'h031A
`define GED_OFS_MASK_LO 16'h031C
`define GED_OFS_MASK_HI 16'h031E
`define GED_OFS_ARM_LO  16'h0320
`define GED_OFS_ARM_HI  16'h0322

// Reset and fill values
`define GED_RST_BIT     1'b0
`define GED_RST_WORD    16'h0000
`define GED_HI_PAD      8'h00
`define GED_PRIME_W     3
`define GED_PRIME_RST   3'h0

`endif

// *** logic/ged_pin_sync.v ***
/*
 Pin synchroniser and edge detector: two flip-flops per pin, then a compare
 of successive synchronised samples. Assumes pins are asynchronous to the clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ged_consts.vh"

module ged_pin_sync #(
	parameter WIDTH = `GED_PINS
) (
	// Clock and reset
	input  wire             i_clk,
	input  wire             i_rst_n,
	// Pins
	input  wire [WIDTH-1:0] i_pin,
	// Edge pulses and ready level
	output wire [WIDTH-1:0] o_rise,
	output wire [WIDTH-1:0] o_fall,
	output wire             o_ready
);

	reg [WIDTH-1:0]        meta;
	reg [WIDTH-1:0]        sync;
	reg [WIDTH-1:0]        prev;
	reg [`GED_PRIME_W-1:0] primed;

	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			meta   <= {WIDTH{`GED_RST_BIT}};
			sync   <= {WIDTH{`GED_RST_BIT}};
			prev   <= {WIDTH{`GED_RST_BIT}};
			primed <= `GED_PRIME_RST;
		end else begin
			meta   <= i_pin;
			sync   <= meta;
			prev   <= sync;
			primed <= {primed[`GED_PRIME_W-2:0], 1'b1};
		end
	end

	// No edges until prev holds a real sample; a pin high at reset is no edge
	assign o_ready = primed[`GED_PRIME_W-1];

	genvar b;
	generate
		for (b = 0; b < WIDTH; b = b + 1) begin : g_bit
			assign o_rise[b] = o_ready & sync[b] & ~prev[b];
			assign o_fall[b] = o_ready & ~sync[b] & prev[b];
		end
	endgenerate

endmodule

`default_nettype wire

// *** logic/ged_edge_irq.v ***
/*
 Edge interrupt detection for 24 general-purpose pins with its register port,
 per-pin sticky status, mask and one level interrupt.
 Assumes one clock, a synchronous active-low reset, pins asynchronous to the
 clock, and a master that never issues read and write strobes together.
*/
// The strobed register port was left to the implementer.
// Operation
// - Rising enable set: rising edge raises status
// - Rising edge is synchronised sample 0 then 1
// - Falling enable set: falling edge raises status
// - Falling edge is synchronised sample 1 then 0
// - Pins 0-15 low register, 16-23 high
// - High rising enable register resets to zero
// - Both falling enable registers reset to zero
// - Status low word per pin, resets zero
// - Status high word holds pins 16-23
// - Writing one then zero clears status bit
`timescale 1ns/1ps
`default_nettype none
`include "ged_consts.vh"

module ged_edge_irq (
	// Clock and reset
	input  wire                   I_CORE_CLK,
	input  wire                   I_RST_N,
	// Pins
	input  wire [`GED_PINS-1:0]   I_PIN,
	// Register port
	input  wire [`GED_ADDR_W-1:0] I_ADDR,
	input  wire [`GED_DATA_W-1:0] I_WR_DATA,
	input  wire                   I_WR_STB,
	input  wire                   I_RD_STB,
	output reg  [`GED_DATA_W-1:0] O_RD_DATA,
	output reg                    O_RD_VALID,
	// Interrupt
	output wire                   O_IRQ,
	output wire [`GED_PINS-1:0]   O_INT_STATUS
);

	// Edge pulses from the synchroniser
	wire [`GED_PINS-1:0] pin_rise;
	wire [`GED_PINS-1:0] pin_fall;

	// Per-pin register bits gathered into words
	wire [`GED_PINS-1:0] rise_en;
	wire [`GED_PINS-1:0] fall_en;
	wire [`GED_PINS-1:0] mask;
	wire [`GED_PINS-1:0] status;
	wire [`GED_PINS-1:0] arm;

	// Write decode
	wire wr_rise_lo;
	wire wr_rise_hi;
	wire wr_fall_lo;
	wire wr_fall_hi;
	wire wr_stat_lo;
	wire wr_stat_hi;
	wire wr_mask_lo;
	wire wr_mask_hi;

	// Read path
	reg  [`GED_DATA_W-1:0] rd_mux;

	ged_pin_sync #(
		.WIDTH (`GED_PINS)
	) u_sync (
		.i_clk   (I_CORE_CLK),
		.i_rst_n (I_RST_N),
		.i_pin   (I_PIN),
		.o_rise  (pin_rise),
		.o_fall  (pin_fall),
		.o_ready ()
	);

	assign wr_rise_lo = I_WR_STB & (I_ADDR == `GED_OFS_RISE_LO);
	assign wr_rise_hi = I_WR_STB & (I_ADDR == `GED_OFS_RISE_HI);
	assign wr_fall_lo = I_WR_STB & (I_ADDR == `GED_OFS_FALL_LO);
	assign wr_fall_hi = I_WR_STB & (I_ADDR == `GED_OFS_FALL_HI);
	assign wr_stat_lo = I_WR_STB & (I_ADDR == `GED_OFS_STAT_LO);
	assign wr_stat_hi = I_WR_STB & (I_ADDR == `GED_OFS_STAT_HI);
	assign wr_mask_lo = I_WR_STB & (I_ADDR == `GED_OFS_MASK_LO);
	assign wr_mask_hi = I_WR_STB & (I_ADDR == `GED_OFS_MASK_HI);

	genvar p;
	generate
		for (p = 0; p < `GED_PINS; p = p + 1) begin : g_pin
			wire sel_rise;
			wire sel_fall;
			wire sel_mask;
			wire sel_stat;
			wire wbit;
			wire hit;
			wire clear_ok;
			reg  rise_q;
			reg  fall_q;
			reg  mask_q;
			reg  stat_q;
			reg  arm_q;
			reg  next_stat;
			reg  next_arm;

			// Low word for pins below 16, high word above
			assign sel_rise = (p < `GED_LO_PINS) ? wr_rise_lo : wr_rise_hi;
			assign sel_fall = (p < `GED_LO_PINS) ? wr_fall_lo : wr_fall_hi;
			assign sel_mask = (p < `GED_LO_PINS) ? wr_mask_lo : wr_mask_hi;
			assign sel_stat = (p < `GED_LO_PINS) ? wr_stat_lo : wr_stat_hi;
			assign wbit     = I_WR_DATA[p % `GED_LO_PINS];

			always @(posedge I_CORE_CLK) begin
				if (!I_RST_N) begin
					rise_q <= `GED_RST_BIT;
				end else if (sel_rise) begin
					rise_q <= wbit;
				end
			end

			always @(posedge I_CORE_CLK) begin
				if (!I_RST_N) begin
					fall_q <= `GED_RST_BIT;
				end else if (sel_fall) begin
					fall_q <= wbit;
				end
			end

			always @(posedge I_CORE_CLK) begin
				if (!I_RST_N) begin
					mask_q <= `GED_RST_BIT;
				end else if (sel_mask) begin
					mask_q <= wbit;
				end
			end

			// Either direction counts when both enables are set
			assign hit = (pin_rise[p] & rise_q) | (pin_fall[p] & fall_q);

			// Zero write only clears after an earlier one write to the same bit
			assign clear_ok = sel_stat & ~wbit & arm_q;

			always @* begin
				next_stat = stat_q;
				if (hit) begin
					next_stat = 1'b1;
				end else if (clear_ok) begin
					next_stat = 1'b0;
				end
			end

			// Arm tracks the first half of the clear sequence
			always @* begin
				next_arm = arm_q;
				if (sel_stat) begin
					next_arm = wbit;
				end
			end

			always @(posedge I_CORE_CLK) begin
				if (!I_RST_N) begin
					stat_q <= `GED_RST_BIT;
					arm_q  <= `GED_RST_BIT;
				end else begin
					stat_q <= next_stat;
					arm_q  <= next_arm;
				end
			end

			assign rise_en[p] = rise_q;
			assign fall_en[p] = fall_q;
			assign mask[p]    = mask_q;
			assign status[p]  = stat_q;
			assign arm[p]     = arm_q;
		end
	endgenerate

	// Unused high bits read as zero
	always @* begin
		rd_mux = `GED_RST_WORD;
		case (I_ADDR)
			`GED_OFS_RISE_LO: begin
				rd_mux = rise_en[`GED_LO_PINS-1:0];
			end
			`GED_OFS_RISE_HI: begin
				rd_mux = {`GED_HI_PAD, rise_en[`GED_PINS-1:`GED_LO_PINS]};
			end
			`GED_OFS_FALL_LO: begin
				rd_mux = fall_en[`GED_LO_PINS-1:0];
			end
			`GED_OFS_FALL_HI: begin
				rd_mux = {`GED_HI_PAD, fall_en[`GED_PINS-1:`GED_LO_PINS]};
			end
			`GED_OFS_STAT_LO: begin
				rd_mux = status[`GED_LO_PINS-1:0];
			end
			`GED_OFS_STAT_HI: begin
				rd_mux = {`GED_HI_PAD, status[`GED_PINS-1:`GED_LO_PINS]};
			end
			`GED_OFS_MASK_LO: begin
				rd_mux = mask[`GED_LO_PINS-1:0];
			end
			`GED_OFS_MASK_HI: begin
				rd_mux = {`GED_HI_PAD, mask[`GED_PINS-1:`GED_LO_PINS]};
			end
			`GED_OFS_ARM_LO: begin
				rd_mux = arm[`GED_LO_PINS-1:0];
			end
			`GED_OFS_ARM_HI: begin
				rd_mux = {`GED_HI_PAD, arm[`GED_PINS-1:`GED_LO_PINS]};
			end
			default: begin
				rd_mux = `GED_RST_WORD;
			end
		endcase
	end

	// Read data stands for exactly one cycle, zero otherwise
	always @(posedge I_CORE_CLK) begin
		if (!I_RST_N) begin
			O_RD_DATA  <= `GED_RST_WORD;
			O_RD_VALID <= 1'b0;
		end else begin
			O_RD_DATA  <= I_RD_STB ? rd_mux : `GED_RST_WORD;
			O_RD_VALID <= I_RD_STB;
		end
	end

	// Level from registers only, so no glitch from edge pulses
	assign O_IRQ        = |(status & mask);
	assign O_INT_STATUS = status;

endmodule

`default_nettype wire

// *** dv/ged_pin_model.sv ***
/* Far-side pin driver for the 24 edge-detect pins.
 Assumes the bench calls set_pins and waits for it. */
`timescale 1ns/1ps
`default_nettype none
module ged_pin_model (
	// Clock
	input  wire logic        i_clk,
	// Pins
	output var  logic [23:0] o_pin
);
	initial o_pin = 24'h000000;
	// Held four cycles so the two-flop synchroniser sees every level
	task automatic set_pins(input logic [23:0] p);
		@(posedge i_clk);
		o_pin <= p;
		repeat (4) @(posedge i_clk);
		#1;
	endtask
endmodule
`default_nettype wire

// *** dv/ged_edge_irq_monitor.sv ***
/* Port checker of ged_edge_irq.
 Assumes it is bound to that module. */
`timescale 1ns/1ps
`default_nettype none
module ged_edge_irq_monitor (
	input wire logic        I_CORE_CLK,
	input wire logic        I_RST_N,
	input wire logic [23:0] I_PIN,
	input wire logic [15:0] I_ADDR,
	input wire logic        I_WR_STB,
	input wire logic        I_RD_STB,
	input wire logic [15:0] O_RD_DATA,
	input wire logic        O_RD_VALID,
	input wire logic        O_IRQ,
	input wire logic [23:0] O_INT_STATUS
);
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RST_N);
	// Long enough for any change to have passed the synchroniser
	sequence quiet_pins;
		$stable(I_PIN) [*4];
	endsequence
	chk_rd_answer: assert property (I_RD_STB |=> O_RD_VALID)
		else $error("no read answer");
	chk_rd_idle: assert property (!I_RD_STB |=> !O_RD_VALID && O_RD_DATA == 16'h0000)
		else $error("idle read data");
	chk_rd_stat_lo: assert property (I_RD_STB && I_ADDR == 16'h0318 |=>
		O_RD_DATA == $past(O_INT_STATUS[15:0])) else $error("status lo read");
	chk_rd_stat_hi: assert property (I_RD_STB && I_ADDR == 16'h031A |=>
		O_RD_DATA == {8'h00, $past(O_INT_STATUS[23:16])}) else $error("status hi read");
	chk_rd_unmapped: assert property (I_RD_STB && I_ADDR == 16'h0400 |=> O_RD_DATA == 16'h0000)
		else $error("unmapped read");
	chk_stat_sticky: assert property (!I_WR_STB |=>
		(O_INT_STATUS & $past(O_INT_STATUS)) == $past(O_INT_STATUS)) else $error("status dropped");
	chk_no_edge: assert property (quiet_pins |=>
		(O_INT_STATUS & ~$past(O_INT_STATUS)) == 24'h000000) else $error("status without edge");
	chk_irq_src: assert property (O_IRQ |-> O_INT_STATUS != 24'h000000)
		else $error("irq without status");
	chk_irq_cause: assert property ($rose(O_IRQ) |-> $past(I_WR_STB) ||
		(O_INT_STATUS & ~$past(O_INT_STATUS)) != 24'h000000) else $error("irq without cause");
endmodule
`default_nettype wire

// *** dv/ged_edge_irq_bench.sv ***
/* Bench for ged_edge_irq: registers, edges, clear, interrupt.
 Assumes the pin model and the monitor are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module ged_edge_irq_bench;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [23:0] pin;
	logic [15:0] addr = 16'h0000;
	logic [15:0] wdata = 16'h0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [15:0] rdata;
	logic        rvalid;
	logic        irq;
	logic [23:0] status;
	int          num_errors = 0;
	int          total_checks = 0;
	int          cycles = 0;
	always #25 clk = ~clk;
	ged_pin_model ged_pin_model_i (.i_clk(clk), .o_pin(pin));
	ged_edge_irq ged_edge_irq_i (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_PIN(pin), .I_ADDR(addr),
		.I_WR_DATA(wdata), .I_WR_STB(wr), .I_RD_STB(rd), .O_RD_DATA(rdata),
		.O_RD_VALID(rvalid), .O_IRQ(irq), .O_INT_STATUS(status));
	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rd_reg(input logic [15:0] a, input logic [15:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		check("rd valid", {23'h000000, rvalid}, 24'h000001);
		check("rd data", {8'h00, rdata}, {8'h00, exp});
	endtask
	task automatic pins(input logic [23:0] p, input logic [23:0] exp);
		ged_pin_model_i.set_pins(p);
		check("status", status, exp);
	endtask
	task automatic t_regs;
		rd_reg(16'h0400, 16'h0000);
		for (int a = 16'h0310; a <= 16'h0322; a += 2)
			rd_reg(a[15:0], 16'h0000);
		wr_reg(16'h0320, 16'hFFFF);
		rd_reg(16'h0320, 16'h0000);
		for (int a = 16'h0310; a <= 16'h031E; a += 2) begin
			if (a[3:0] == 4'h8 || a[3:0] == 4'hA)
				continue;
			wr_reg(a[15:0], 16'hFFFF);
			rd_reg(a[15:0], a[1] ? 16'h00FF : 16'hFFFF);
			wr_reg(a[15:0], 16'h0000);
		end
	endtask
	task automatic t_rise;
		wr_reg(16'h0310, 16'h0001);
		wr_reg(16'h0312, 16'h0080);
		pins(24'h800003, 24'h800001);
		rd_reg(16'h0318, 16'h0001);
		rd_reg(16'h031A, 16'h0080);
		pins(24'h000000, 24'h800001);
		check("irq", {23'h000000, irq}, 24'h000000);
		wr_reg(16'h031E, 16'h0080);
		check("irq", {23'h000000, irq}, 24'h000001);
		wr_reg(16'h031E, 16'h0000);
		check("irq", {23'h000000, irq}, 24'h000000);
	endtask
	task automatic t_clear;
		wr_reg(16'h0318, 16'h0000);
		check("status", status, 24'h800001);
		wr_reg(16'h031A, 16'h0080);
		rd_reg(16'h0322, 16'h0080);
		wr_reg(16'h031A, 16'h0000);
		wr_reg(16'h0318, 16'h0001);
		wr_reg(16'h0318, 16'h0000);
		check("status", status, 24'h000000);
	endtask
	task automatic t_fall;
		wr_reg(16'h0314, 16'h0002);
		wr_reg(16'h0316, 16'h0001);
		wr_reg(16'h0312, 16'h0001);
		pins(24'h000002, 24'h000000);
		pins(24'h010000, 24'h010002);
		wr_reg(16'h031A, 16'h0001);
		wr_reg(16'h031A, 16'h0000);
		pins(24'h000000, 24'h010002);
	endtask
	task automatic t_reset;
		wr_reg(16'h0316, 16'h00FF);
		wr_reg(16'h031C, 16'hFFFF);
		check("irq", {23'h000000, irq}, 24'h000001);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		check("irq", {23'h000000, irq}, 24'h000000);
		check("status", status, 24'h000000);
		for (int a = 16'h0310; a <= 16'h031E; a += 2)
			rd_reg(a[15:0], 16'h0000);
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Run takes about 150 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			final_report();
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_rise();
		t_clear();
		t_fall();
		t_reset();
		final_report();
	end
endmodule
bind ged_edge_irq ged_edge_irq_monitor ged_edge_irq_monitor_i (.I_CORE_CLK(I_CORE_CLK),
	.I_RST_N(I_RST_N), .I_PIN(I_PIN), .I_ADDR(I_ADDR), .I_WR_STB(I_WR_STB), .I_RD_STB(I_RD_STB),
	.O_RD_DATA(O_RD_DATA), .O_RD_VALID(O_RD_VALID), .O_IRQ(O_IRQ), .O_INT_STATUS(O_INT_STATUS));
`default_nettype wire
